// *** inc/swpsc_pkg.sv ***
// Purpose: shared types and constants for the switch power state controller
// Assumes: single 40 MHz clock, APB register access
// Notes: the standby delay figure is a plain default, shortened in simulation
package swpsc_pkg;

    // operating states of the switch
    typedef enum logic [2:0] {
        ST_SLEEP = 3'b000,
        ST_DIAG = 3'b001,
        ST_ACTIVE = 3'b010,
        ST_STBY = 3'b011,
        ST_LPM = 3'b100
    } swpsc_state_type;

    // what the sense output is told to present
    typedef enum logic [1:0] {
        SNS_OFF = 2'b00,
        SNS_ZERO = 2'b01,
        SNS_PROPORTIONAL = 2'b10,
        SNS_FAULT_HIGH = 2'b11
    } swpsc_sense_type;

    // clock and standby delay
    localparam int CLK_PERIOD_NS = 25;
    localparam int STBY_TIME_US = 1000;
    localparam int STBY_CYCLES = STBY_TIME_US * 1000 / CLK_PERIOD_NS;
    localparam int COUNT_W = 32;

    // register map, byte addresses
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFS_STATUS = 8'h00;
    localparam logic [7:0] OFS_CTRL = 8'h04;

    // status field positions
    localparam int ST_STATE_LSB = 0;
    localparam int ST_CHAN_LSB = 3;
    localparam int ST_UVLO_BIT = 5;
    localparam int ST_FAULT_BIT = 6;
    localparam int ST_LPM_BIT = 7;
    localparam int ST_SENSE_LSB = 8;

    // control field positions and reset value
    localparam int CTRL_DIAG_BIT = 0;
    localparam logic CTRL_DIAG_RESET = 1'b0;

    // whole state of the controller
    typedef struct packed {
        swpsc_state_type state;
        logic [COUNT_W-1:0] count;
        logic uv_lockout;
        logic diag_prev;
        logic sw_diag;
        logic [1:0] channel_on;
        logic fault_level;
        logic fault_oe_n;
        swpsc_sense_type sense;
        logic low_power_mode;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } swpsc_regs_type;

    // fault pin released, everything else cleared
    localparam swpsc_regs_type REGS_RESET = '{
        state: ST_SLEEP,
        count: 32'h0000_0000,
        uv_lockout: 1'b0,
        diag_prev: 1'b0,
        sw_diag: CTRL_DIAG_RESET,
        channel_on: 2'h0,
        fault_level: 1'b0,
        fault_oe_n: 1'b1,
        sense: SNS_OFF,
        low_power_mode: 1'b0,
        prdata: 32'h0000_0000,
        pready: 1'b0,
        pslverr: 1'b0
    };

endpackage

// *** rtl/swpsc_controller.sv ***
// Purpose: operating state controller of a dual channel high side switch
// Assumes: all pin inputs synchronous to pclk; analog comparators outside
// Notes: fault pin is open drain, output enable low while pulling low
//
// Local design decisions: register access over APB and the register offsets.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// R1 - shut down at fall threshold, resume at rise
// R2 - ground loss disables every channel
// R3 - supply loss switches every output off
// R4 - sleep: all off, leave only on enable or diagnostic enable
// R5 - sleep exits to active, else diagnostic
// R6 - supply below fall threshold forces sleep
// R7 - diagnostic enable rising enters diagnostic state from sleep or standby, active from low power
// R8 - off-state diagnostics: open load, short to battery
// R9 - fault pin any channel, sense selected only
// R10 - diagnostic enable low: active or standby delay
// R11 - any channel on means active state
// R12 - active with diagnostics: sense proportional until fault
// R13 - active: fault pin reports any channel
// R14 - all off in active: diagnostic or standby
// R15 - standby delay elapses, then sleep
// R16 - standby: enable to active, diagnostic to diagnostic
// R17 - low current past delay enters low power
// R18 - low power: protected, no diagnostics or faults
// R19 - open-drain fault pin, silent in sleep, low power
// R20 - one counter, restarts when condition lapses
module swpsc_controller #(
    parameter int unsigned STBY_CYCLES = swpsc_pkg::STBY_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [swpsc_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [1:0] channel_enable_n,
    input wire logic diagnostic_enable,
    input wire logic channel_select,
    input wire logic supply_at_fall,
    input wire logic supply_at_rise,
    input wire logic ground_lost,
    input wire logic supply_lost,
    input wire logic [1:0] load_below_lpm,
    input wire logic [1:0] overcurrent_fault,
    input wire logic [1:0] offstate_fault,
    output logic [1:0] channel_on,
    output logic fault_flag_n_out,
    output logic fault_flag_n_oe_n,
    output swpsc_pkg::swpsc_sense_type sense_output,
    output logic low_power_mode
);

    ////////////////////////////////////////////////////////////////////////
    // state and derived conditions

    swpsc_pkg::swpsc_regs_type r;
    swpsc_pkg::swpsc_regs_type next_r;

    logic diag;
    logic diag_rise;
    logic any_en;
    logic low_cur;
    logic next_uv;
    logic powered;
    logic delay_done;
    logic qualify;
    logic [1:0] ch_fault;
    logic report;
    logic sel_en;
    logic apb_setup;
    logic apb_done;
    logic hit_status;
    logic hit_ctrl;
    logic [31:0] status_word;

    // last count value of the shared delay, then the next edge moves on
    localparam logic [swpsc_pkg::COUNT_W-1:0] COUNT_LAST =
        swpsc_pkg::COUNT_W'(STBY_CYCLES - 1);

    // pin and software request for diagnostics
    assign diag = diagnostic_enable | r.sw_diag;
    assign diag_rise = diag & ~r.diag_prev;
    assign any_en = |channel_enable_n;
    // every enabled channel under the entry current
    assign low_cur = &(load_below_lpm | ~channel_enable_n);
    assign delay_done = r.count >= COUNT_LAST;
    assign sel_en = channel_enable_n[channel_select];

    // undervoltage lockout with hysteresis
    always_comb begin
        next_uv = r.uv_lockout;
        if (supply_at_fall) begin
            next_uv = 1'b1; // see R1
        end else if (supply_at_rise) begin
            next_uv = 1'b0; // see R1
        end
    end

    // loss of ground or supply removes all power
    assign powered = ~next_uv & ~ground_lost & ~supply_lost; // see R2 see R3

    // per channel faults: on-state overcurrent, off-state when diagnosing
    assign ch_fault = (channel_enable_n & overcurrent_fault)
        | (~channel_enable_n & offstate_fault & {2{diag}}); // see R8

    ////////////////////////////////////////////////////////////////////////
    // apb decode

    assign apb_setup = psel & penable & ~r.pready;
    assign apb_done = psel & penable & r.pready;
    assign hit_status = paddr == swpsc_pkg::OFS_STATUS;
    assign hit_ctrl = paddr == swpsc_pkg::OFS_CTRL;

    // status word seen by software
    always_comb begin
        status_word = 32'h0000_0000;
        status_word[swpsc_pkg::ST_STATE_LSB +: 3] = r.state;
        status_word[swpsc_pkg::ST_CHAN_LSB +: 2] = r.channel_on;
        status_word[swpsc_pkg::ST_UVLO_BIT] = r.uv_lockout;
        status_word[swpsc_pkg::ST_FAULT_BIT] = ~r.fault_oe_n;
        status_word[swpsc_pkg::ST_LPM_BIT] = r.low_power_mode;
        status_word[swpsc_pkg::ST_SENSE_LSB +: 2] = r.sense;
    end

    ////////////////////////////////////////////////////////////////////////
    // next state of everything

    always_comb begin
        next_r = r;
        next_r.uv_lockout = next_uv;
        next_r.diag_prev = diag;
        next_r.fault_level = 1'b0;

        // operating state machine
        unique case (r.state)
            swpsc_pkg::ST_SLEEP: begin
                if (any_en) begin
                    next_r.state = swpsc_pkg::ST_ACTIVE; // see R5
                end else if (diag) begin
                    next_r.state = swpsc_pkg::ST_DIAG; // see R4 see R5
                end
            end
            swpsc_pkg::ST_DIAG: begin
                if (any_en) begin
                    next_r.state = swpsc_pkg::ST_ACTIVE; // see R11
                end else if (!diag) begin
                    next_r.state = swpsc_pkg::ST_STBY; // see R10
                end
            end
            swpsc_pkg::ST_ACTIVE: begin
                if (!any_en) begin
                    next_r.state = diag ? swpsc_pkg::ST_DIAG
                        : swpsc_pkg::ST_STBY; // see R14
                end else if (low_cur && !diag && delay_done) begin
                    next_r.state = swpsc_pkg::ST_LPM; // see R17
                end
            end
            swpsc_pkg::ST_STBY: begin
                if (any_en) begin
                    next_r.state = swpsc_pkg::ST_ACTIVE; // see R16
                end else if (diag) begin
                    next_r.state = swpsc_pkg::ST_DIAG; // see R16 see R7
                end else if (delay_done) begin
                    next_r.state = swpsc_pkg::ST_SLEEP; // see R15
                end
            end
            swpsc_pkg::ST_LPM: begin
                if (!any_en) begin
                    next_r.state = swpsc_pkg::ST_STBY;
                end else if (diag_rise || diag || !low_cur) begin
                    next_r.state = swpsc_pkg::ST_ACTIVE; // see R7
                end
            end
            default: begin
                next_r.state = swpsc_pkg::ST_SLEEP;
            end
        endcase

        // no power overrides every state
        if (!powered) begin
            next_r.state = swpsc_pkg::ST_SLEEP; // see R6 see R1
        end

        // shared delay counter restarts whenever its condition lapses
        qualify = (r.state == swpsc_pkg::ST_STBY)
            || (r.state == swpsc_pkg::ST_ACTIVE && any_en && low_cur && !diag);
        if (qualify && next_r.state == r.state) begin
            if (!delay_done) begin
                next_r.count = r.count + 1'b1; // see R20
            end
        end else begin
            next_r.count = '0; // see R20
        end

        // channels conduct only in active or low power
        if (next_r.state == swpsc_pkg::ST_ACTIVE
            || next_r.state == swpsc_pkg::ST_LPM) begin
            next_r.channel_on = channel_enable_n; // see R11
        end else begin
            next_r.channel_on = 2'h0; // see R4 see R2 see R3
        end
        next_r.low_power_mode = next_r.state == swpsc_pkg::ST_LPM;

        // fault pin: any channel, silent in sleep and low power
        report = next_r.state == swpsc_pkg::ST_DIAG
            || next_r.state == swpsc_pkg::ST_ACTIVE
            || next_r.state == swpsc_pkg::ST_STBY;
        next_r.fault_oe_n = ~(report && |ch_fault); // see R9 see R13 see R19

        // sense pin follows the selected channel only
        next_r.sense = swpsc_pkg::SNS_OFF; // see R18
        if (diag && (next_r.state == swpsc_pkg::ST_DIAG
            || next_r.state == swpsc_pkg::ST_ACTIVE)) begin
            if (ch_fault[channel_select]) begin
                next_r.sense = swpsc_pkg::SNS_FAULT_HIGH; // see R9
            end else if (next_r.state == swpsc_pkg::ST_ACTIVE && sel_en) begin
                next_r.sense = swpsc_pkg::SNS_PROPORTIONAL; // see R12
            end else begin
                next_r.sense = swpsc_pkg::SNS_ZERO;
            end
        end

        // apb slave: one wait state, error on unmapped address
        next_r.pready = apb_setup;
        if (apb_setup) begin
            next_r.pslverr = ~(hit_status | hit_ctrl);
            next_r.prdata = 32'h0000_0000;
            if (!pwrite && hit_status) begin
                next_r.prdata = status_word;
            end else if (!pwrite && hit_ctrl) begin
                next_r.prdata[swpsc_pkg::CTRL_DIAG_BIT] = r.sw_diag;
            end
        end else begin
            next_r.pslverr = 1'b0;
        end
        if (apb_done && pwrite && hit_ctrl) begin
            next_r.sw_diag = pwdata[swpsc_pkg::CTRL_DIAG_BIT];
        end
    end

    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= swpsc_pkg::REGS_RESET;
        end else begin
            r <= next_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs straight from flops

    assign prdata = r.prdata;
    assign pready = r.pready;
    assign pslverr = r.pslverr;
    assign channel_on = r.channel_on;
    assign fault_flag_n_out = r.fault_level;
    assign fault_flag_n_oe_n = r.fault_oe_n;
    assign sense_output = r.sense;
    assign low_power_mode = r.low_power_mode;

    ////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // supply stays good across the next edge
    logic steady_power;
    assign steady_power = !supply_at_fall && !ground_lost && !supply_lost
        && !(r.uv_lockout && !supply_at_rise);

    sequence s_stby_expiry;
        r.state == swpsc_pkg::ST_STBY && delay_done && !any_en && !diag
            && steady_power;
    endsequence

    sequence s_active_fault;
        r.state == swpsc_pkg::ST_ACTIVE && steady_power
            && |(channel_enable_n & overcurrent_fault);
    endsequence

    a_uv_sleep: assert property ( // see R6
        supply_at_fall
            |=> r.state == swpsc_pkg::ST_SLEEP && channel_on == 2'h0
    ) else $error("undervoltage did not force sleep");

    a_uv_hold: assert property ( // see R1
        r.uv_lockout && !supply_at_rise |=> r.state == swpsc_pkg::ST_SLEEP
    ) else $error("woke before rise threshold");

    a_gnd_loss_off: assert property ( // see R2
        ground_lost |=> channel_on == 2'h0
    ) else $error("channel on after ground loss");

    a_supply_loss_off: assert property ( // see R3
        supply_lost |=> channel_on == 2'h0 && !low_power_mode
    ) else $error("channel on after supply loss");

    a_sleep_stays: assert property ( // see R4
        r.state == swpsc_pkg::ST_SLEEP && !any_en && !diag
            |=> r.state == swpsc_pkg::ST_SLEEP && channel_on == 2'h0
    ) else $error("left sleep without request");

    a_sleep_to_active: assert property ( // see R5
        r.state == swpsc_pkg::ST_SLEEP && any_en && steady_power
            |=> r.state == swpsc_pkg::ST_ACTIVE
            && channel_on == $past(channel_enable_n)
    ) else $error("sleep did not wake to active");

    a_diag_release: assert property ( // see R10
        r.state == swpsc_pkg::ST_DIAG && !diag && !any_en && steady_power
            |=> r.state == swpsc_pkg::ST_STBY
    ) else $error("diagnostic release not to standby");

    a_stby_timeout: assert property ( // see R15
        s_stby_expiry |=> r.state == swpsc_pkg::ST_SLEEP ##1 fault_flag_n_oe_n
    ) else $error("standby delay did not end in sleep");

    a_count_restart: assert property ( // see R20
        r.state != $past(r.state) |-> r.count == '0
    ) else $error("delay counter kept running across states");

    a_active_fault: assert property ( // see R13
        s_active_fault ##0 any_en |=> !fault_flag_n_oe_n
    ) else $error("active fault not reported");

    a_lpm_quiet: assert property ( // see R18
        low_power_mode
            |-> fault_flag_n_oe_n && sense_output == swpsc_pkg::SNS_OFF
    ) else $error("reporting while in low power");

endmodule

`default_nettype wire

// *** verif/swpsc_mcu_model.sv ***
// Purpose: microcontroller side of the switch: control pins, fault line
// Assumes: commands change just after a rising pclk edge
// Notes: fault line carries an external pull-up to the logic supply
`timescale 1ns/1ps
`default_nettype none

module swpsc_mcu_model (
    input wire logic [1:0] cmd_en,
    input wire logic cmd_diag,
    input wire logic cmd_sel,
    input wire logic fault_flag_n_out,
    input wire logic fault_flag_n_oe_n,
    output logic [1:0] channel_enable_n,
    output logic diagnostic_enable,
    output logic channel_select,
    output logic fault_pin
);
    // control pins follow the commands, launched just after an edge
    assign channel_enable_n = cmd_en;
    assign diagnostic_enable = cmd_diag;
    assign channel_select = cmd_sel;
    // pull-up holds the line high unless the switch pulls it low
    assign fault_pin = fault_flag_n_oe_n ? 1'h1 : fault_flag_n_out;
endmodule

`default_nettype wire

// *** verif/tb_top.sv ***
// Purpose: self-checking bench of the switch power state controller
// Assumes: pins and APB driven by non-blocking assignment at rising pclk or 1 ns after it
// Notes: standby count shortened to 8 cycles
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [1:0] cmd_en, channel_enable_n, channel_on;
    logic cmd_diag, cmd_sel, diagnostic_enable, channel_select;
    logic supply_at_fall, supply_at_rise, ground_lost, supply_lost;
    logic [1:0] load_below_lpm, overcurrent_fault, offstate_fault;
    logic fault_flag_n_out, fault_flag_n_oe_n, fault_pin, low_power_mode;
    swpsc_pkg::swpsc_sense_type sense_output;
    int n_fail, num_checks;

    ////////////////////////////////////////////////////////////////////////
    // design and microcontroller model
    swpsc_controller #(.STBY_CYCLES(8)) DUT (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr),
        .channel_enable_n(channel_enable_n),
        .diagnostic_enable(diagnostic_enable),
        .channel_select(channel_select), .supply_at_fall(supply_at_fall),
        .supply_at_rise(supply_at_rise), .ground_lost(ground_lost),
        .supply_lost(supply_lost), .load_below_lpm(load_below_lpm),
        .overcurrent_fault(overcurrent_fault),
        .offstate_fault(offstate_fault), .channel_on(channel_on),
        .fault_flag_n_out(fault_flag_n_out),
        .fault_flag_n_oe_n(fault_flag_n_oe_n),
        .sense_output(sense_output), .low_power_mode(low_power_mode)
    );
    swpsc_mcu_model mcu (
        .cmd_en(cmd_en), .cmd_diag(cmd_diag), .cmd_sel(cmd_sel),
        .fault_flag_n_out(fault_flag_n_out),
        .fault_flag_n_oe_n(fault_flag_n_oe_n),
        .channel_enable_n(channel_enable_n),
        .diagnostic_enable(diagnostic_enable),
        .channel_select(channel_select), .fault_pin(fault_pin)
    );

    ////////////////////////////////////////////////////////////////////////
    // shared tasks
    task automatic chk(input string what, input logic [31:0] seen,
            input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask

    // one apb transfer, held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a,
            input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'h1;
        // look at the settled answer between edges, act on the next edge
        do begin
            @(negedge pclk);
            n++;
        end while (pready !== 1'h1 && n < 20);
        chk("pready", pready, 1'h1);
        rd = prdata;
        err = pslverr;
        @(posedge pclk);
        psel <= 1'h0;
        penable <= 1'h0;
    endtask

    task automatic st(input swpsc_pkg::swpsc_state_type s);
        apb(1'h0, swpsc_pkg::OFS_STATUS, 32'h0000_0000);
        chk("state", {29'h0000_0000, rd[2:0]}, {29'h0000_0000, s});
    endtask

    ////////////////////////////////////////////////////////////////////////
    // scenarios
    task automatic t_reset;
        @(posedge pclk);
        offstate_fault <= 2'h1;
        tick(3);
        chk("fault in sleep", fault_pin, 1'h1);
        chk("channels", channel_on, 2'h0);
        st(swpsc_pkg::ST_SLEEP);
        offstate_fault <= 2'h0;
        apb(1'h0, swpsc_pkg::OFS_CTRL, 32'h0000_0000);
        chk("ctrl reset", rd, 32'h0000_0000);
        apb(1'h0, 8'h08, 32'h0000_0000);
        chk("unmapped err", err, 1'h1);
        chk("unmapped data", rd, 32'h0000_0000);
    endtask

    task automatic t_ctrl;
        apb(1'h1, swpsc_pkg::OFS_CTRL, 32'h0000_0001);
        apb(1'h0, swpsc_pkg::OFS_CTRL, 32'h0000_0000);
        chk("ctrl", rd, 32'h0000_0001);
        st(swpsc_pkg::ST_DIAG);
        apb(1'h1, swpsc_pkg::OFS_CTRL, 32'h0000_0000);
        st(swpsc_pkg::ST_STBY);
        tick(20);
        st(swpsc_pkg::ST_SLEEP);
    endtask

    task automatic t_diag;
        @(posedge pclk);
        cmd_diag <= 1'h1;
        offstate_fault <= 2'h2;
        tick(3);
        st(swpsc_pkg::ST_DIAG);
        chk("fault any", fault_pin, 1'h0);
        chk("sns oth", sense_output, swpsc_pkg::SNS_ZERO);
        @(posedge pclk);
        cmd_sel <= 1'h1;
        tick(3);
        chk("sense sel", sense_output, swpsc_pkg::SNS_FAULT_HIGH);
        offstate_fault <= 2'h0;
        cmd_diag <= 1'h0;
        tick(3);
        st(swpsc_pkg::ST_STBY);
        @(posedge pclk);
        cmd_en <= 2'h1;
        tick(3);
        st(swpsc_pkg::ST_ACTIVE);
    endtask

    task automatic t_active;
        @(posedge pclk);
        cmd_diag <= 1'h1;
        cmd_sel <= 1'h0;
        tick(3);
        chk("sns prop", sense_output, swpsc_pkg::SNS_PROPORTIONAL);
        chk("channel on", channel_on, 2'h1);
        overcurrent_fault <= 2'h1;
        tick(3);
        chk("sense flt", sense_output, swpsc_pkg::SNS_FAULT_HIGH);
        chk("fault act", fault_pin, 1'h0);
        overcurrent_fault <= 2'h0;
        cmd_en <= 2'h0;
        tick(3);
        st(swpsc_pkg::ST_DIAG);
        cmd_diag <= 1'h0;
        tick(20);
        st(swpsc_pkg::ST_SLEEP);
    endtask

    task automatic t_lpm;
        @(posedge pclk);
        cmd_en <= 2'h1;
        load_below_lpm <= 2'h1;
        tick(5);
        load_below_lpm <= 2'h0;
        @(posedge pclk);
        load_below_lpm <= 2'h1;
        tick(5);
        chk("lpm restart", low_power_mode, 1'h0);
        tick(10);
        chk("lpm", low_power_mode, 1'h1);
        overcurrent_fault <= 2'h1;
        tick(3);
        chk("fault lpm", fault_pin, 1'h1);
        chk("lpm on", channel_on, 2'h1);
        overcurrent_fault <= 2'h0;
        load_below_lpm <= 2'h0;
        tick(3);
    endtask

    task automatic t_supply;
        @(posedge pclk);
        supply_at_fall <= 1'h1;
        supply_at_rise <= 1'h0;
        tick(3);
        chk("uv off", channel_on, 2'h0);
        st(swpsc_pkg::ST_SLEEP);
        supply_at_fall <= 1'h0;
        tick(3);
        chk("uv hold", channel_on, 2'h0);
        supply_at_rise <= 1'h1;
        tick(3);
        chk("uv on", channel_on, 2'h1);
        ground_lost <= 1'h1;
        tick(3);
        chk("gnd lost", channel_on, 2'h0);
        ground_lost <= 1'h0;
        supply_lost <= 1'h1;
        tick(3);
        chk("sup lost", channel_on, 2'h0);
        supply_lost <= 1'h0;
        cmd_en <= 2'h0;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // verdict, clock, watchdog and main sequence
    task automatic summarize;
        $display("checks %0d failures %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    initial begin
        pclk = 1'h0;
        forever #12.5 pclk = ~pclk;
    end

    // cuts a hang well past the roughly two hundred cycles of the tests
    initial begin
        repeat (5000) @(posedge pclk);
        n_fail++;
        summarize();
    end

    initial begin
        {presetn, psel, penable, pwrite, cmd_diag, cmd_sel} = 6'h00;
        {supply_at_fall, ground_lost, supply_lost} = 3'h0;
        supply_at_rise = 1'h1;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        {cmd_en, load_below_lpm, overcurrent_fault, offstate_fault} = 8'h00;
        n_fail = 0;
        num_checks = 0;
        repeat (16) @(posedge pclk);
        presetn <= 1'h1;
        t_reset();
        t_ctrl();
        t_diag();
        t_active();
        t_lpm();
        t_supply();
        tick(3);
        summarize();
    end
endmodule

`default_nettype wire
